//--- bench/sac_gate_properties.sv
// Concurrent checks on the ports of the register access gate
`timescale 1ns/100ps
`include "sac_map.vh"
module sac_gate_properties (
  // Clock and reset
  input logic ref_clk,
  input logic reset,
  // Core port
  input logic wr_strobe,
  input logic rd_strobe,
  input logic [7:0] addr,
  input logic [7:0] wdata,
  input logic [7:0] rdata,
  input logic denied,
  // Mode and state
  input logic [2:0] cpu_mode,
  input logic [15:0] seg_rights,
  input logic [15:0] seg_table_addr,
  input logic [7:0] firewall_low_out,
  input logic [15:0] xchg_window
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);
  wire acc = wr_strobe | rd_strobe;
  property p_idle; !rd_strobe |=> rdata == 8'h00; endproperty
  a_idle: assert property (p_idle) else $error("rdata set without read");
  property p_key; rd_strobe && addr[7:1] == 7'h51 |=> rdata == 8'h00; endproperty
  a_key: assert property (p_key) else $error("key readable");
  property p_rpt; rd_strobe && addr >= 8'h81 && addr <= 8'h83 |=> rdata == 8'h00; endproperty
  a_rpt: assert property (p_rpt) else $error("reset protect readable");
  property p_seg; wr_strobe && addr == `SAC_A_SEG_TABLE_LOW && cpu_mode != `SAC_MODE_SYS |=> $stable(seg_table_addr);
  endproperty
  a_seg: assert property (p_seg) else $error("segment pointer written");
  property p_rst; $fell(reset) |-> seg_table_addr == 16'h0000; endproperty
  a_rst: assert property (p_rst) else $error("segment pointer not cleared");
  property p_fwro; wr_strobe && addr == `SAC_A_FIREWALL_CONTROL_LOW && cpu_mode == `SAC_MODE_CLOS
    |=> $stable(firewall_low_out); endproperty
  a_fwro: assert property (p_fwro) else $error("firewall written");
  property p_fwsys; wr_strobe && addr == `SAC_A_FIREWALL_CONTROL_LOW && cpu_mode == `SAC_MODE_SYS
    |=> firewall_low_out == $past(wdata); endproperty
  a_fwsys: assert property (p_fwsys) else $error("firewall write lost");
  property p_cpu; acc && addr == `SAC_A_CPU_ACC |=> !denied; endproperty
  a_cpu: assert property (p_cpu) else $error("cpu register denied");
  property p_open; acc && cpu_mode <= `SAC_MODE_TEST && addr == `SAC_A_GP0 |=> !denied; endproperty
  a_open: assert property (p_open) else $error("boot or test denied");
  property p_user; rd_strobe && cpu_mode == `SAC_MODE_USER && addr == `SAC_A_GP0 && !seg_rights[4]
    |=> denied && rdata == 8'h00; endproperty
  a_user: assert property (p_user) else $error("user read not refused");
  property p_clk; rd_strobe && cpu_mode == `SAC_MODE_CLOS && addr == `SAC_A_CLOCK_SOURCE_SELECT |=> !denied;
  endproperty
  a_clk: assert property (p_clk) else $error("clock select denied");
  property p_xchg; wr_strobe && addr == `SAC_A_XCHG_BASE && cpu_mode != `SAC_MODE_SYS |=> $stable(xchg_window);
  endproperty
  a_xchg: assert property (p_xchg) else $error("window written");
  c_user: cover property (rd_strobe && cpu_mode == `SAC_MODE_USER ##1 denied);
  c_clos: cover property (wr_strobe && cpu_mode == `SAC_MODE_CLOS ##1 denied);
  c_sys: cover property (wr_strobe && cpu_mode == `SAC_MODE_SYS ##1 !denied);
endmodule // sac_gate_properties
bind sac_gate sac_gate_properties chk (.ref_clk(ref_clk), .reset(reset), .wr_strobe(wr_strobe),
  .rd_strobe(rd_strobe), .addr(addr), .wdata(wdata), .rdata(rdata), .denied(denied), .cpu_mode(cpu_mode),
  .seg_rights(seg_rights), .seg_table_addr(seg_table_addr), .firewall_low_out(firewall_low_out),
  .xchg_window(xchg_window));

//--- bench/sac_rng_model.sv
// Model of the hardware random source feeding the gate
`timescale 1ns/100ps
module sac_rng_model (
  // Clock
  input logic ref_clk,
  // Value to present
  input logic [7:0] level,
  // Source output
  output logic [7:0] random_in
);
  // Moves only on the core clock, so the gate's synchroniser sees clean steps
  initial random_in = 8'h00;
  always @(posedge ref_clk) begin
    random_in <= level;
  end
endmodule // sac_rng_model

//--- bench/tb.sv
// Self-checking bench of the register access gate
`timescale 1ns/100ps
`include "sac_map.vh"
module tb;
  logic ref_clk, reset, wr_strobe, rd_strobe, denied, k, w, ok;
  logic [7:0] addr, wdata, rdata, level, random_in, r, fw_high, clk_sel;
  logic [7:0] gp [0:1];
  logic [2:0] cpu_mode;
  logic [15:0] seg_rights, seg_table_addr, xchg_window, rt;
  integer failures, n_compared, cycles, i;
  sac_rng_model rng (.ref_clk(ref_clk), .level(level), .random_in(random_in));
  sac_gate dut (.ref_clk(ref_clk), .reset(reset), .addr(addr), .wdata(wdata), .wr_strobe(wr_strobe),
    .rd_strobe(rd_strobe), .rdata(rdata), .cpu_mode(cpu_mode), .seg_rights(seg_rights), .random_in(random_in),
    .denied(denied), .seg_table_addr(seg_table_addr), .firewall_low_out(), .firewall_high_out(fw_high),
    .xchg_window(xchg_window), .clock_select_out(clk_sel));
  function [7:0] lfsr(input [7:0] s);
    lfsr = {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  // Rights word: read bit at index, write bit eight above
  function hw_ok(input [15:0] rw, input [2:0] ix, input wr);
    hw_ok = wr ? rw[ix + 8] : rw[ix];
  endfunction
  task chk(input string nm, input [15:0] exp, input [15:0] got);
    n_compared = n_compared + 1;
    if (got !== exp) begin
      failures = failures + 1;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // A refusal flag of x means the flag is left unchecked
  task acc(input wr, input [7:0] a, input [7:0] d, input [7:0] e, input den);
    @(posedge ref_clk);
    addr <= a;
    wdata <= d;
    wr_strobe <= wr;
    rd_strobe <= !wr;
    @(posedge ref_clk);
    wr_strobe <= 1'b0;
    rd_strobe <= 1'b0;
    #1;
    if (den !== 1'bx) chk("denied", den, denied);
    if (!wr) chk("rdata", e, rdata);
  endtask
  task close_out;
    $display("Compared %0d mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    cycles = cycles + 1;
    if (cycles == 5000) begin
      failures = failures + 1;
      close_out;
    end
  end
  initial begin
    failures = 0; n_compared = 0; cycles = 0; r = 8'h54; level = r; gp[0] = 8'h00; gp[1] = 8'h00;
    reset = 1'b1; wr_strobe = 1'b0; rd_strobe = 1'b0; addr = 8'h00; wdata = 8'h00;
    cpu_mode = `SAC_MODE_SYS; seg_rights = 16'h0000;
    repeat (3) @(posedge ref_clk);
    reset <= 1'b0;
    #1 chk("seg_table_addr", 16'h0000, seg_table_addr);
    r = lfsr(r);
    acc(1, `SAC_A_SEG_TABLE_LOW, r, 0, 0);
    chk("seg_table_addr", {8'h00, r}, seg_table_addr);
    acc(1, `SAC_A_FIREWALL_CONTROL_LOW, 8'h10, 0, 0);
    acc(0, `SAC_A_FIREWALL_CONTROL_LOW, 0, 8'h10, 0);
    acc(1, `SAC_A_XCHG_BASE, 8'h5a, 0, 0);
    acc(1, `SAC_A_FIREWALL_CONTROL_HIGH, 8'h20, 0, 0);
    chk("firewall_high_out", 16'h0020, {8'h00, fw_high});
    acc(1, `SAC_A_CLOCK_SOURCE_SELECT, 8'h3e, 0, 0);
    // Clock select copy trails the register by one cycle
    @(posedge ref_clk);
    #1 chk("clock_select_out", 16'h003e, {8'h00, clk_sel});
    acc(1, 8'h94, 8'hff, 0, 1);
    acc(0, 8'h94, 0, 0, 1);
    for (i = 0; i < 2; i = i + 1) begin
      cpu_mode <= i[2:0];
      acc(1, `SAC_A_SEG_TABLE_LOW, 8'hff, 0, 1);
      chk("seg_table_addr", {8'h00, r}, seg_table_addr);
      gp[0] = 8'h3c + i[7:0];
      acc(1, `SAC_A_GP0, gp[0], 0, 0);
      acc(0, `SAC_A_GP0, 0, gp[0], 0);
      acc(1, `SAC_A_CIPHER_KEY_A, 8'ha5, 0, 0);
      acc(0, `SAC_A_CIPHER_KEY_A + i[7:0], 0, 0, 1);
      acc(1, `SAC_A_RANDOM_NUMBER_REG, ~level, 0, 1);
      acc(0, `SAC_A_RANDOM_NUMBER_REG, 0, level, 0);
    end
    acc(0, `SAC_A_RESET_PROTECT_A, 0, 0, 1);
    acc(0, `SAC_A_RESET_PROTECT_B, 0, 0, 1);
    acc(0, `SAC_A_RESET_PROTECT_C, 0, 0, 1);
    cpu_mode <= `SAC_MODE_CLOS;
    acc(1, `SAC_A_FIREWALL_CONTROL_LOW, 8'hff, 0, 1);
    acc(0, `SAC_A_FIREWALL_CONTROL_LOW, 0, 8'h10, 0);
    acc(1, `SAC_A_CLOS_DATA, 8'h77, 0, 0);
    acc(0, `SAC_A_CLOS_DATA, 0, 8'h77, 0);
    acc(0, `SAC_A_CLOCK_SOURCE_SELECT, 0, 8'h3e, 0);
    acc(1, `SAC_A_GP0, 8'h99, 0, 1);
    acc(0, `SAC_A_GP0, 0, gp[0], 0);
    acc(0, `SAC_A_GP1, 0, 0, 1);
    acc(1, `SAC_A_GP1, 8'h66, 0, 0);
    gp[1] = 8'h66;
    acc(0, `SAC_A_PROGRAM_STATUS_HIGH, 0, 8'h00, 0);
    acc(1, `SAC_A_XCHG_BASE, 8'h11, 0, 1);
    chk("xchg_window", 16'h005a, xchg_window);
    cpu_mode <= `SAC_MODE_USER;
    acc(0, `SAC_A_PROGRAM_STATUS_HIGH, 0, 8'h00, 0);
    acc(0, `SAC_A_FIREWALL_CONTROL_LOW, 0, 0, 1);
    acc(1, `SAC_A_SEG_TABLE_HIGH, 8'h01, 0, 1);
    for (i = 0; i < 60; i = i + 1) begin
      r = lfsr(r);
      rt = {2'b00, r[1:0], 4'h0, 2'b00, r[3:2], 4'h0};
      seg_rights <= rt;
      cpu_mode <= r[6] ? `SAC_MODE_SYS : `SAC_MODE_USER;
      k = r[4];
      w = r[5];
      ok = r[6] | hw_ok(rt, 3'h4 + {2'b00, k}, w);
      r = lfsr(r);
      acc(w, `SAC_A_GP0 + {7'h00, k}, r, ok ? gp[k] : 8'h00, !ok);
      if (w && ok) gp[k] = r;
    end
    // Second reset after the pointer was written must clear it again
    reset <= 1'b1;
    @(posedge ref_clk);
    reset <= 1'b0;
    #1 chk("seg_table_addr", 16'h0000, seg_table_addr);
    for (i = 0; i < 5; i = i + 1) begin
      cpu_mode <= i[2:0];
      acc(1, `SAC_A_CPU_ACC, i[7:0], 0, 0);
      acc(0, `SAC_A_CPU_ACC, 0, i[7:0], 0);
    end
    close_out;
  end
endmodule // tb

//--- core/sac_gate.v
// Special function register file with mode-based access gate
//
// The implementer's own choices: the address map and the address-and-strobe port.
`timescale 1ns/100ps
`include "sac_map.vh"
module sac_gate (
  // Clock and reset
  input wire ref_clk,
  input wire reset,
  // Core register port
  input wire [7:0] addr,
  input wire [7:0] wdata,
  input wire wr_strobe,
  input wire rd_strobe,
  output reg [7:0] rdata,
  // Mode and rights from the core and MMU
  input wire [2:0] cpu_mode,
  input wire [15:0] seg_rights,
  // Hardware side inputs
  input wire [7:0] random_in,
  // Status and configuration outputs
  output reg denied,
  output reg [15:0] seg_table_addr,
  output reg [7:0] firewall_low_out,
  output reg [7:0] firewall_high_out,
  output reg [15:0] xchg_window,
  output reg [7:0] clock_select_out
);
  // ----------------------------------------
  // Decode and decision, same cycle
  // ----------------------------------------
  wire [2:0] group;
  wire [2:0] hw_index;
  wire rd_ok;
  wire wr_ok;
  reg [7:0] psw_high;
  reg [7:0] rp_a;
  reg [7:0] rp_b;
  reg [7:0] rp_c;
  reg [7:0] clos_data;
  reg [7:0] cpu_acc;
  reg [7:0] cpu_b;
  reg [7:0] hw_reg [0:`SAC_HW_COUNT-1];
  reg [7:0] rng_sync1;
  reg [7:0] rng_sync2;
  reg [7:0] next_rdata;
  wire wr_go;

  sac_group_decode u_dec (
    .addr(addr),
    .group(group),
    .hw_index(hw_index)
  );

  sac_rights u_rights (
    .mode(cpu_mode),
    .addr(addr),
    .group(group),
    .hw_index(hw_index),
    .fw_low(firewall_low_out),
    .fw_high(firewall_high_out),
    .seg_rights(seg_rights),
    .rd_ok(rd_ok),
    .wr_ok(wr_ok)
  );

  assign wr_go = wr_strobe && wr_ok;

  // ----------------------------------------
  // Random source crosses in from its own logic
  // ----------------------------------------
  always @(posedge ref_clk) begin
    if (reset) begin
      rng_sync1 <= `SAC_RST_REG;
      rng_sync2 <= `SAC_RST_REG;
    end else begin
      rng_sync1 <= random_in;
      rng_sync2 <= rng_sync1;
    end
  end

  // ----------------------------------------
  // Register writes
  // ----------------------------------------
  // Segment table pointer clears to zero so no user segment is live after reset
  always @(posedge ref_clk) begin
    if (reset) begin
      seg_table_addr <= {`SAC_RST_SEG_TABLE, `SAC_RST_SEG_TABLE};
      firewall_low_out <= `SAC_RST_REG;
      firewall_high_out <= `SAC_RST_REG;
      xchg_window <= {`SAC_RST_REG, `SAC_RST_REG};
      psw_high <= `SAC_RST_MODE_REG;
      rp_a <= `SAC_RST_REG;
      rp_b <= `SAC_RST_REG;
      rp_c <= `SAC_RST_REG;
      clos_data <= `SAC_RST_REG;
      cpu_acc <= `SAC_RST_REG;
      cpu_b <= `SAC_RST_REG;
    end else if (wr_go) begin
      case (addr)
        `SAC_A_SEG_TABLE_LOW: seg_table_addr[7:0] <= wdata;
        `SAC_A_SEG_TABLE_HIGH: seg_table_addr[15:8] <= wdata;
        `SAC_A_FIREWALL_CONTROL_LOW: firewall_low_out <= wdata;
        `SAC_A_FIREWALL_CONTROL_HIGH: firewall_high_out <= wdata;
        `SAC_A_XCHG_BASE: xchg_window[7:0] <= wdata;
        `SAC_A_XCHG_SIZE: xchg_window[15:8] <= wdata;
        `SAC_A_PROGRAM_STATUS_HIGH: psw_high <= wdata;
        `SAC_A_RESET_PROTECT_A: rp_a <= wdata;
        `SAC_A_RESET_PROTECT_B: rp_b <= wdata;
        `SAC_A_RESET_PROTECT_C: rp_c <= wdata;
        `SAC_A_CLOS_DATA: clos_data <= wdata;
        `SAC_A_CPU_ACC: cpu_acc <= wdata;
        `SAC_A_CPU_B: cpu_b <= wdata;
        default: begin
        end
      endcase
    end
  end
  // Partition has no register at all; it is fixed by construction
  // Segment table lives in memory, so its contents are outside this gate

  // Hardware component registers, one per index
  genvar gi;
  generate
    for (gi = 0; gi < `SAC_HW_COUNT; gi = gi + 1) begin : g_hw
      always @(posedge ref_clk) begin
        if (reset) begin
          hw_reg[gi] <= `SAC_RST_REG;
        end else if (gi == `SAC_HW_IDX_RNG) begin
          hw_reg[gi] <= rng_sync2;
        end else if (wr_go && group == `SAC_GRP_HW && hw_index == gi) begin
          hw_reg[gi] <= wdata;
        end
      end
    end
  endgenerate

  // ----------------------------------------
  // Read path
  // ----------------------------------------
  always @* begin
    next_rdata = 8'h00;
    if (rd_ok) begin
      case (group)
        `SAC_GRP_HW: next_rdata = hw_reg[hw_index];
        default: begin
          case (addr)
            `SAC_A_SEG_TABLE_LOW: next_rdata = seg_table_addr[7:0];
            `SAC_A_SEG_TABLE_HIGH: next_rdata = seg_table_addr[15:8];
            `SAC_A_FIREWALL_CONTROL_LOW: next_rdata = firewall_low_out;
            `SAC_A_FIREWALL_CONTROL_HIGH: next_rdata = firewall_high_out;
            `SAC_A_XCHG_BASE: next_rdata = xchg_window[7:0];
            `SAC_A_XCHG_SIZE: next_rdata = xchg_window[15:8];
            `SAC_A_PROGRAM_STATUS_HIGH: next_rdata = psw_high;
            `SAC_A_CLOS_DATA: next_rdata = clos_data;
            `SAC_A_CPU_ACC: next_rdata = cpu_acc;
            `SAC_A_CPU_B: next_rdata = cpu_b;
            default: next_rdata = 8'h00;
          endcase
        end
      endcase
    end
  end

  // Zero rather than hold keeps a denied read from leaking the last value
  always @(posedge ref_clk) begin
    if (reset) begin
      rdata <= 8'h00;
      denied <= 1'b0;
      clock_select_out <= `SAC_RST_REG;
    end else begin
      rdata <= rd_strobe ? next_rdata : 8'h00;
      denied <= (rd_strobe && !rd_ok) || (wr_strobe && !wr_ok);
      clock_select_out <= hw_reg[`SAC_HW_IDX_CLOCK_SOURCE_SELECT];
    end
  end
endmodule // sac_gate

//--- core/sac_group_decode.v
// Address to register group and hardware index decoder
`timescale 1ns/100ps
`include "sac_map.vh"
module sac_group_decode (
  // Access address
  input wire [7:0] addr,
  // Decoded class
  output reg [2:0] group,
  output reg [2:0] hw_index
);
  always @* begin
    group = `SAC_GRP_NONE;
    hw_index = 3'h0;
    case (addr)
      `SAC_A_CPU_ACC, `SAC_A_CPU_B: group = `SAC_GRP_CPU;
      `SAC_A_PROGRAM_STATUS_HIGH, `SAC_A_RESET_PROTECT_A, `SAC_A_RESET_PROTECT_B,
      `SAC_A_RESET_PROTECT_C: group = `SAC_GRP_SYSM;
      `SAC_A_SEG_TABLE_LOW, `SAC_A_SEG_TABLE_HIGH: group = `SAC_GRP_SEG;
      `SAC_A_FIREWALL_CONTROL_LOW, `SAC_A_FIREWALL_CONTROL_HIGH, `SAC_A_XCHG_BASE,
      `SAC_A_XCHG_SIZE: group = `SAC_GRP_FW;
      `SAC_A_CLOS_DATA: group = `SAC_GRP_CLOS;
      default: begin
        if (addr >= `SAC_A_HW_BASE && addr < (`SAC_A_HW_BASE + 8'h06)) begin
          group = `SAC_GRP_HW;
          hw_index = addr[2:0];
        end
      end
    endcase
  end
endmodule // sac_group_decode

//--- core/sac_map.vh
// Address map, field positions, reset values and group codes of the register access gate
`ifndef SAC_MAP_VH
`define SAC_MAP_VH
// ----------------------------------------
// CPU modes
// ----------------------------------------
`define SAC_MODE_BOOT 3'h0
`define SAC_MODE_TEST 3'h1
`define SAC_MODE_CLOS 3'h2
`define SAC_MODE_SYS 3'h3
`define SAC_MODE_USER 3'h4
// ----------------------------------------
// Register groups
// ----------------------------------------
`define SAC_GRP_CPU 3'h0
`define SAC_GRP_SEG 3'h1
`define SAC_GRP_SYSM 3'h2
`define SAC_GRP_FW 3'h3
`define SAC_GRP_CLOS 3'h4
`define SAC_GRP_HW 3'h5
`define SAC_GRP_NONE 3'h6
// ----------------------------------------
// Register addresses (8-bit space)
// ----------------------------------------
`define SAC_A_PROGRAM_STATUS_HIGH 8'h80
`define SAC_A_RESET_PROTECT_A 8'h81
`define SAC_A_RESET_PROTECT_B 8'h82
`define SAC_A_RESET_PROTECT_C 8'h83
`define SAC_A_SEG_TABLE_LOW 8'h88
`define SAC_A_SEG_TABLE_HIGH 8'h89
`define SAC_A_FIREWALL_CONTROL_LOW 8'h90
`define SAC_A_FIREWALL_CONTROL_HIGH 8'h91
`define SAC_A_XCHG_BASE 8'h92
`define SAC_A_XCHG_SIZE 8'h93
`define SAC_A_CLOS_DATA 8'h98
`define SAC_A_HW_BASE 8'ha0
`define SAC_A_CLOCK_SOURCE_SELECT 8'ha0
`define SAC_A_RANDOM_NUMBER_REG 8'ha1
`define SAC_A_CIPHER_KEY_A 8'ha2
`define SAC_A_CIPHER_KEY_B 8'ha3
`define SAC_A_GP0 8'ha4
`define SAC_A_GP1 8'ha5
`define SAC_A_CPU_ACC 8'he0
`define SAC_A_CPU_B 8'hf0
// ----------------------------------------
// Hardware register fields
// ----------------------------------------
`define SAC_HW_COUNT 6
`define SAC_HW_IDX_W 3
`define SAC_HW_IDX_CLOCK_SOURCE_SELECT 3'h0
`define SAC_HW_IDX_RNG 3'h1
`define SAC_HW_IDX_KEYA 3'h2
`define SAC_HW_IDX_KEYB 3'h3
// Firewall low: read right per hw index in bits 5..0; high: write right in bits 5..0
// Segment rights input: same layout, read in [5:0], write in [13:8]
`define SAC_SEG_WR_POS 8
`define SAC_SEG_RIGHTS_W 16
// ----------------------------------------
// Reset values
// ----------------------------------------
`define SAC_RST_SEG_TABLE 8'h00
`define SAC_RST_REG 8'h00
`define SAC_RST_MODE_REG 8'h00
`endif

//--- core/sac_rights.v
// Per-mode grant decision for one access
`timescale 1ns/100ps
`include "sac_map.vh"
module sac_rights (
  // Access description
  input wire [2:0] mode,
  input wire [7:0] addr,
  input wire [2:0] group,
  input wire [2:0] hw_index,
  // Rights sources
  input wire [7:0] fw_low,
  input wire [7:0] fw_high,
  input wire [15:0] seg_rights,
  // Decision
  output reg rd_ok,
  output reg wr_ok
);
  always @* begin
    rd_ok = 1'b0;
    wr_ok = 1'b0;
    case (mode)
      `SAC_MODE_BOOT, `SAC_MODE_TEST: begin
        rd_ok = 1'b1;
        wr_ok = 1'b1;
      end
      `SAC_MODE_CLOS: begin
        if (group == `SAC_GRP_FW) begin
          rd_ok = 1'b1;
        end else if (group == `SAC_GRP_CLOS) begin
          rd_ok = 1'b1;
          wr_ok = 1'b1;
        end else if (group == `SAC_GRP_HW) begin
          rd_ok = fw_low[hw_index] || (hw_index == `SAC_HW_IDX_CLOCK_SOURCE_SELECT);
          wr_ok = fw_high[hw_index];
        end else if (addr == `SAC_A_PROGRAM_STATUS_HIGH) begin
          rd_ok = 1'b1;
        end
      end
      `SAC_MODE_SYS: begin
        if (group == `SAC_GRP_SEG || group == `SAC_GRP_SYSM || group == `SAC_GRP_FW ||
            group == `SAC_GRP_HW) begin
          rd_ok = 1'b1;
          wr_ok = 1'b1;
        end
      end
      `SAC_MODE_USER: begin
        if (group == `SAC_GRP_HW) begin
          rd_ok = seg_rights[hw_index];
          wr_ok = seg_rights[`SAC_SEG_WR_POS + hw_index];
        end else if (addr == `SAC_A_PROGRAM_STATUS_HIGH) begin
          rd_ok = 1'b1;
        end
      end
      default: begin
        rd_ok = 1'b0;
        wr_ok = 1'b0;
      end
    endcase
    // Segmentation registers only in system mode; boot and test lose them too
    if (group == `SAC_GRP_SEG && mode != `SAC_MODE_SYS) begin
      rd_ok = 1'b0;
      wr_ok = 1'b0;
    end
    if (group == `SAC_GRP_CPU) begin
      rd_ok = 1'b1;
      wr_ok = 1'b1;
    end
    // Exchange window steers shared RAM, so only system code may move it
    if ((addr == `SAC_A_XCHG_BASE || addr == `SAC_A_XCHG_SIZE) && mode != `SAC_MODE_SYS) begin
      wr_ok = 1'b0;
    end
    if (addr == `SAC_A_RESET_PROTECT_A || addr == `SAC_A_RESET_PROTECT_B ||
        addr == `SAC_A_RESET_PROTECT_C) begin
      rd_ok = 1'b0;
    end
    if (group == `SAC_GRP_HW && hw_index == `SAC_HW_IDX_RNG) begin
      wr_ok = 1'b0;
    end
    if (group == `SAC_GRP_HW && (hw_index == `SAC_HW_IDX_KEYA || hw_index == `SAC_HW_IDX_KEYB)) begin
      rd_ok = 1'b0;
    end
  end
endmodule // sac_rights
